//--- hdl/irpr_top.sv
// I2C target read path for eight registers arranged as four pairs.
module irpr_top
  import irpr_pkg::*;
(
  // Core clock, reset, enable
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // Link clock (the bus clock line)
  input  wire logic              SCL_CLK,
  // Bus pins
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE,
  // Target address
  input  wire logic [ADDR_W-1:0] DEV_ADDR,
  // Register sources
  input  wire logic [PORT_W-1:0] PORT_PIN,
  input  wire logic [PORT_W-1:0] OUT_LATCH,
  input  wire logic [PORT_W-1:0] POL_INV,
  input  wire logic [PORT_W-1:0] DIR_CFG,
  // Status and events
  output logic      [1:0]        INT_CLR,
  output logic      [SEL_W-1:0]  RD_PTR
);

  // Synchronised pins.
  logic [PORT_W-1:0] pin_s;
  logic              scl_s;
  logic              sda_s;
  logic              scl_q;
  logic              sda_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic [PORT_W-1:0] in_reg;

  // Core state.
  irpr_state_t       state;
  irpr_state_t       next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] next_shift;
  logic              rw;
  logic              next_rw;
  logic [SEL_W-1:0]  ptr;
  logic [SEL_W-1:0]  next_ptr;
  logic [SEL_W-1:0]  sent_sel;
  logic [SEL_W-1:0]  next_sent_sel;
  logic              ack_oe;
  logic              next_ack_oe;
  logic              want;
  logic              next_want;
  logic              tx_load;
  logic              next_tx_load;
  logic              tx_run;
  logic              next_tx_run;
  logic [DATA_W-1:0] tx_hold;
  logic [DATA_W-1:0] next_tx_hold;
  logic [1:0]        int_clr;
  logic [1:0]        next_int_clr;
  logic              drive_en;
  logic              next_drive_en;

  // Byte path.
  logic [DATA_W-1:0] sel_byte;
  logic              push_ready;
  logic              pop_valid;
  logic              pop_ready;
  logic [DATA_W-1:0] pop_data;
  logic              flush;

  // Link state.
  logic [DATA_W-1:0] lnk_shreg;
  logic [DATA_W-1:0] next_lnk_shreg;
  logic              lnk_oe;
  logic              next_lnk_oe;

  irpr_sync #(
    .WIDTH (PORT_W + 2)
  ) u_pin_sync (
    .clk (CORE_CLK),
    .rst (RST),
    .en  (CE),
    .d   ({PORT_PIN, SCL_IN, SDA_IN}),
    .q   ({pin_s, scl_s, sda_s})
  );

  for (genvar i = 0; i < PORT_W; i++) begin : g_inv
    assign in_reg[i] = pin_s[i] ^ POL_INV[i];
  end

  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
  assign flush     = start_det || stop_det;

  always_comb begin
    case (ptr[2:1])
      PAIR_INPUT:    sel_byte = in_reg[ptr[0]*DATA_W +: DATA_W];
      PAIR_OUTPUT:   sel_byte = OUT_LATCH[ptr[0]*DATA_W +: DATA_W];
      PAIR_POLARITY: sel_byte = POL_INV[ptr[0]*DATA_W +: DATA_W];
      PAIR_CONFIG:   sel_byte = DIR_CFG[ptr[0]*DATA_W +: DATA_W];
      default:       sel_byte = '0;
    endcase
  end

  // Byte values are taken at the acknowledge bit and drained into the link holding register.
  irpr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .en        (CE),
    .flush     (flush),
    .in_valid  (want),
    .in_ready  (push_ready),
    .in_data   (sel_byte),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  assign pop_ready = ((state == ST_ADDR_ACK) || (state == ST_RDATA_ACK)) && !tx_load;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_shift    = shift;
    next_rw       = rw;
    next_ptr      = ptr;
    next_sent_sel = sent_sel;
    next_ack_oe   = ack_oe;
    next_want     = want;
    next_tx_load  = tx_load;
    next_tx_run   = tx_run;
    next_tx_hold  = tx_hold;
    next_int_clr  = 2'h0;
    // Producer stalls until the FIFO takes the byte.
    // alternate pair member
    if (want && push_ready) begin
      next_want     = 1'b0;
      next_sent_sel = ptr;
      next_ptr      = {ptr[2:1], ~ptr[0]};
    end
    // hand byte to link before ack falls
    if (pop_valid && pop_ready) begin
      next_tx_hold = pop_data;
      next_tx_load = 1'b1;
    end
    if (start_det || stop_det) begin
      next_state   = start_det ? ST_ADDR : ST_IDLE;
      next_cnt     = '0;
      next_ack_oe  = 1'b0;
      next_want    = 1'b0;
      next_tx_load = 1'b0;
      next_tx_run  = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise && cnt != BITS_DONE) begin
            next_shift = {shift[DATA_W-2:0], sda_s};
            next_cnt   = CNT_W'(cnt + 1'b1);
          end else if (scl_fall && cnt == BITS_DONE) begin
            next_cnt    = '0;
            next_ack_oe = 1'b1;
            if (state == ST_ADDR) begin
              if (shift[DATA_W-1:1] == DEV_ADDR) begin
                next_rw    = shift[0];
                next_state = ST_ADDR_ACK;
                // first byte is the selected register
                next_want  = (shift[0] == RW_READ);
              end else begin
                next_ack_oe = 1'b0;
                next_state  = ST_IDLE;
              end
            end else if (state == ST_CMD) begin
              next_ptr   = shift[SEL_W-1:0];
              next_state = ST_CMD_ACK;
            end else begin
              next_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_ack_oe  = 1'b0;
            next_tx_load = 1'b0;
            if (state == ST_ADDR_ACK && rw == RW_READ) begin
              next_state  = ST_RDATA;
              next_tx_run = 1'b1;
            end else begin
              next_state = (state == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise && cnt != BITS_DONE) begin
            next_cnt = CNT_W'(cnt + 1'b1);
            if (cnt == LAST_BIT) begin
              next_tx_run = 1'b0;
            end
          end else if (scl_fall && cnt == BITS_DONE) begin
            next_cnt   = '0;
            next_state = ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            // clear change flag of port read
            if (sent_sel[2:1] == PAIR_INPUT) begin
              next_int_clr[sent_sel[0]] = 1'b1;
            end
            next_want = (sda_s == LEVEL_ACK);
          end else if (scl_fall) begin
            next_want    = 1'b0;
            next_tx_load = 1'b0;
            if (tx_load) begin
              next_state  = ST_RDATA;
              next_tx_run = 1'b1;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_IDLE, ST_WAIT: begin
          next_state = state;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    next_drive_en = (next_state == ST_RDATA);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state    <= ST_IDLE;
      cnt      <= '0;
      shift    <= '0;
      rw       <= 1'b0;
      ptr      <= PTR_RESET;
      sent_sel <= PTR_RESET;
      ack_oe   <= 1'b0;
      want     <= 1'b0;
      tx_load  <= 1'b0;
      tx_run   <= 1'b0;
      tx_hold  <= '0;
      int_clr  <= 2'h0;
      drive_en <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else if (CE) begin
      state    <= next_state;
      cnt      <= next_cnt;
      shift    <= next_shift;
      rw       <= next_rw;
      ptr      <= next_ptr;
      sent_sel <= next_sent_sel;
      ack_oe   <= next_ack_oe;
      want     <= next_want;
      tx_load  <= next_tx_load;
      tx_run   <= next_tx_run;
      tx_hold  <= next_tx_hold;
      int_clr  <= next_int_clr;
      drive_en <= next_drive_en;
      scl_q    <= scl_s;
      sda_q    <= sda_s;
    end
  end

  // Link side runs on the bus clock falling edge. The core changes tx_load, tx_run and
  // tx_hold only just after it sees a bus clock edge, rising or falling, so they have settled well
  // before the falling edge that samples them; this relies on the core clock being
  // far faster than the bus clock.
  always_comb begin
    next_lnk_shreg = lnk_shreg;
    next_lnk_oe    = 1'b0;
    if (tx_load) begin
      next_lnk_shreg = tx_hold;
      next_lnk_oe    = ~tx_hold[DATA_W-1];
    end else if (tx_run) begin
      next_lnk_shreg = {lnk_shreg[DATA_W-2:0], 1'b0};
      next_lnk_oe    = ~lnk_shreg[DATA_W-2];
    end
  end

  always_ff @(negedge SCL_CLK) begin
    lnk_shreg <= next_lnk_shreg;
    lnk_oe    <= next_lnk_oe;
  end

  // The core gate keeps the pin released in reset and after a not-acknowledge,
  // even if the bus clock has stopped and the link flops hold stale values.
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = ack_oe || (lnk_oe && drive_en);
  assign INT_CLR = int_clr;
  assign RD_PTR  = ptr;

endmodule

//--- include/irpr_pkg.sv
// Constants and types for the I2C register-pair read block.
// How it works
// - First byte returned after a new command byte is the register that byte picks.
// - Byte to send is taken during the acknowledge bit and loaded into the link at its clock's falling edge.
// - Each further byte comes from the other register of the same pair.
// - Bytes keep coming while the controller acknowledges; no byte limit.
// - Pointer survives a restart; next read gives the pair member after the last.
// - Reset puts pointer and bus state machine at their defaults.
// - Eight registers as four pairs; pair members differ only in address bit 0.
// - Output-latch reads return the latched value, not the pin level.
// - Input reads return the complemented pin where the inversion bit is set.
// - Reading the port with a pending change clears it at the acknowledge bit.
package irpr_pkg;

  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PORT_W     = 16;
  localparam int ADDR_W     = 7;
  localparam int SEL_W      = 3;
  localparam int CNT_W      = 4;

  // Pair codes are command bits 2:1; bit 0 picks the pair member.
  localparam logic [1:0] PAIR_INPUT    = 2'h0;
  localparam logic [1:0] PAIR_OUTPUT   = 2'h1;
  localparam logic [1:0] PAIR_POLARITY = 2'h2;
  localparam logic [1:0] PAIR_CONFIG   = 2'h3;

  localparam logic [SEL_W-1:0] PTR_RESET   = 3'h0;
  localparam logic [CNT_W-1:0] BITS_DONE   = 4'h8;
  localparam logic [CNT_W-1:0] LAST_BIT    = 4'h7;
  localparam logic             RW_READ     = 1'b1;
  localparam logic             LEVEL_ACK   = 1'b0;
  localparam int               CORE_CLK_NS = 10;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_WAIT
  } irpr_state_t;

endpackage

//--- hdl/irpr_sync.sv
// Two-flop synchroniser for levels entering the core clock domain.
module irpr_sync
  import irpr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (en) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

//--- hdl/irpr_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
module irpr_fifo
  import irpr_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (do_push) begin
        next_wr_ptr = AW'(wr_ptr + 1'b1);
      end
      if (do_pop) begin
        next_rd_ptr = AW'(rd_ptr + 1'b1);
      end
      if (do_push && !do_pop) begin
        next_count = (AW + 1)'(count + 1'b1);
      end else if (do_pop && !do_push) begin
        next_count = (AW + 1)'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; words are only read while counted valid.
  always_ff @(posedge clk) begin
    if (en && do_push && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Read data come from a register; a word written into the next head slot bypasses the array.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_data <= '0;
    end else if (en) begin
      if (do_push && (wr_ptr == next_rd_ptr)) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[next_rd_ptr];
      end
    end
  end

endmodule

//--- tb/irpr_top_assertions.sv
// Port-level checks for the register-pair read block.
module irpr_top_assertions
  import irpr_pkg::*;
(
  // Clock and reset
  input wire logic             CORE_CLK,
  input wire logic             RST,
  // Bus pins
  input wire logic             SCL_IN,
  input wire logic             SDA_OUT,
  input wire logic             SDA_OE,
  // Status and events
  input wire logic [1:0]       INT_CLR,
  input wire logic [SEL_W-1:0] RD_PTR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  a_reset_quiet: assert property (disable iff (1'b0)
    RST |=> !SDA_OE && INT_CLR == 2'h0 && RD_PTR == PTR_RESET) else $error("reset state");
  a_sda_open_drain: assert property (SDA_OUT == 1'b0) else $error("data driven high");
  a_bit_steady: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
    else $error("data moved while clock high");
  a_ptr_once: assert property ($changed(RD_PTR) |=> $stable(RD_PTR) [*8])
    else $error("pointer moved twice");
  a_oe_released: assert property ($rose(SDA_OE) |-> ##[1:1000] !SDA_OE)
    else $error("data line held");
  a_clr_pulse: assert property (INT_CLR != 2'h0 |=> (INT_CLR == 2'h0) [*8])
    else $error("clear pulse too long");
  a_clr_input_pair: assert property (INT_CLR != 2'h0 |->
    RD_PTR[2:1] == PAIR_INPUT && $onehot(INT_CLR)) else $error("clear outside input pair");
  a_clr_at_ack: assert property (INT_CLR != 2'h0 |-> !SDA_OE)
    else $error("clear while device drives");
  a_clr_member: assert property (INT_CLR != 2'h0 |-> !INT_CLR[RD_PTR[0]])
    else $error("clear for wrong port");
endmodule

//--- tb/irpr_ctrl_model.sv
// Behavioural bus controller that reads register pairs from the target.
module irpr_ctrl_model
  import irpr_pkg::*;
#(
  parameter int QTR = 20
) (
  // Clock
  input  wire logic clk,
  // Bus
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic wait_q();
    repeat (QTR) @(posedge clk);
  endtask
  // Data only moves while the clock is low, so no false start is seen.
  task automatic bit_cycle(input logic val, output logic smp);
    pull <= ~val;
    wait_q();
    scl <= 1'b1;
    wait_q();
    smp = sda;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask
  task automatic start();
    pull <= 1'b0;
    wait_q();
    scl <= 1'b1;
    wait_q();
    pull <= 1'b1;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask
  task automatic stop();
    pull <= 1'b1;
    wait_q();
    scl <= 1'b1;
    wait_q();
    pull <= 1'b0;
    wait_q();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, b[i]);
    end
    bit_cycle(~ack, s);
  endtask
endmodule

//--- tb/irpr_top_tb.sv
// Self-checking testbench for the register-pair read block.
module irpr_top_tb
  import irpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [ADDR_W-1:0] DEV   = 7'h2a;
  localparam logic [PORT_W-1:0] LATCH = 16'ha5c3;
  localparam logic [PORT_W-1:0] POL   = 16'h0ff0;
  localparam logic [PORT_W-1:0] CFG   = 16'h5e71;
  logic              core_clk;
  logic              rst;
  logic              scl;
  logic              pull;
  logic              sda;
  logic              sda_oe;
  logic [1:0]        int_clr;
  logic [SEL_W-1:0]  rd_ptr;
  logic [SEL_W-1:0]  ptr_exp;
  logic [PORT_W-1:0] pin;
  int                int_cnt;
  int                error_cnt;
  int                num_checks;

  // Pulled-up open-drain wire: high unless a party pulls it low.
  assign sda = ~(sda_oe | pull);

  irpr_top i_irpr_top (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .SCL_CLK(scl),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .DEV_ADDR(DEV),
    .PORT_PIN(pin), .OUT_LATCH(LATCH), .POL_INV(POL), .DIR_CFG(CFG),
    .INT_CLR(int_clr), .RD_PTR(rd_ptr));
  irpr_ctrl_model i_irpr_ctrl_model (.clk(core_clk), .scl(scl), .pull(pull), .sda(sda));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (int_clr !== 2'h0) int_cnt++;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [7:0] reg_val(input logic [2:0] p);
    logic [15:0] w;
    case (p[2:1])
      PAIR_INPUT:    w = pin ^ POL;
      PAIR_OUTPUT:   w = LATCH;
      PAIR_POLARITY: w = POL;
      default:       w = CFG;
    endcase
    return p[0] ? w[15:8] : w[7:0];
  endfunction
  // Optional command phase, then restart and n bytes; ends without a stop.
  task automatic do_read(input logic [7:0] cmd, input int n, input logic new_cmd);
    logic       ack;
    logic [7:0] b;
    logic [2:0] p;
    int         c0;
    c0 = int_cnt;
    p = new_cmd ? cmd[2:0] : ptr_exp;
    if (new_cmd) begin
      i_irpr_ctrl_model.start();
      i_irpr_ctrl_model.wbyte({DEV, 1'b0}, ack);
      check(8'(ack), 8'h01, "write address ack");
      i_irpr_ctrl_model.wbyte(cmd, ack);
      check(8'(ack), 8'h01, "command ack");
    end
    i_irpr_ctrl_model.start();
    i_irpr_ctrl_model.wbyte({DEV, 1'b1}, ack);
    check(8'(ack), 8'h01, "read address ack");
    for (int i = 0; i < n; i++) begin
      i_irpr_ctrl_model.rbyte(i < n - 1, b);
      check(b, reg_val(p), "read byte");
      p = p ^ 3'h1;
    end
    check(8'(rd_ptr), 8'(p), "pointer after read");
    check(8'(int_cnt - c0), (p[2:1] == PAIR_INPUT) ? 8'(n) : 8'h00, "clear pulses");
    ptr_exp = p;
  endtask

  task automatic test_reset();
    check(8'(sda_oe), 8'h00, "idle drive");
    check(8'(int_clr), 8'h00, "idle clear");
    check(8'(rd_ptr), 8'h00, "idle pointer");
    $display("Test reset state done");
  endtask
  task automatic test_all_regs();
    for (int c = 0; c < 8; c++) begin
      do_read(8'(c), 3, 1'b1);
      i_irpr_ctrl_model.stop();
    end
    $display("Test all registers done");
  endtask
  task automatic test_restart();
    pin <= 16'h3c69;
    do_read(8'h03, 3, 1'b1);
    do_read(8'h00, 2, 1'b0);
    i_irpr_ctrl_model.stop();
    $display("Test restart done");
  endtask
  task automatic test_write_ignored();
    logic ack;
    i_irpr_ctrl_model.start();
    i_irpr_ctrl_model.wbyte({DEV, 1'b0}, ack);
    i_irpr_ctrl_model.wbyte(8'h06, ack);
    i_irpr_ctrl_model.wbyte(8'h5a, ack);
    check(8'(ack), 8'h01, "write data ack");
    i_irpr_ctrl_model.wbyte(8'h3c, ack);
    check(8'(ack), 8'h01, "second data ack");
    i_irpr_ctrl_model.stop();
    check(8'(rd_ptr), 8'h06, "pointer after write");
    ptr_exp = 3'h6;
    $display("Test write ignored done");
  endtask
  task automatic test_wrong_addr();
    logic ack;
    i_irpr_ctrl_model.start();
    i_irpr_ctrl_model.wbyte({DEV ^ 7'h01, 1'b0}, ack);
    check(8'(ack), 8'h00, "foreign address");
    i_irpr_ctrl_model.stop();
    $display("Test foreign address done");
  endtask
  task automatic test_mid_reset();
    do_read(8'h05, 2, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(8'(rd_ptr), 8'h00, "pointer after reset");
    ptr_exp = PTR_RESET;
    do_read(8'h00, 1, 1'b0);
    i_irpr_ctrl_model.stop();
    $display("Test mid-run reset done");
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    pin = 16'h3c96;
    ptr_exp = PTR_RESET;
    int_cnt = 0;
    error_cnt = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    test_reset();
    test_all_regs();
    test_restart();
    test_write_ignored();
    test_wrong_addr();
    test_mid_reset();
    complete_run();
  end
  // Bus traffic needs about 52000 cycles; cut a hang well beyond that.
  initial begin
    repeat (95000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
endmodule

bind irpr_top irpr_top_assertions i_irpr_top_assertions (.CORE_CLK(CORE_CLK), .RST(RST),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .INT_CLR(INT_CLR), .RD_PTR(RD_PTR));
